// ===== core/tbn_node_cfg.sv
// The placing of the registers and the APB slave port were chosen for this implementation.
module tbn_node_cfg #(
    parameter int MS_CYCLES = tbn_pkg::MS_CYCLES,
    parameter int REFRESH_CYCLES = tbn_pkg::REFRESH_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // front panel switches
    input wire logic [3:0] addr_tens_sw,
    input wire logic [3:0] addr_ones_sw,
    input wire logic [3:0] unit_sw,
    output logic comm_error_lamp,
    // network side
    input wire logic [61:0] node_part,
    input wire logic token_return,
    input wire logic ev_req,
    output logic [5:0] token_next,
    output logic cycle_strobe,
    output logic poll_strobe,
    output logic [5:0] poll_addr,
    output logic ev_grant,
    output logic ev_deny,
    output logic route_local,
    // host memory write port
    output logic host_wr,
    output logic host_area,
    output logic [15:0] host_addr,
    output logic [15:0] host_data
);

    typedef struct packed {
        logic [11:0] sw_s1;
        logic [11:0] sw_s2;
        logic [61:0] part_s1;
        logic [61:0] part_s2;
        logic tok_s1;
        logic tok_s2;
        logic tok_s3;
        logic strap_done;
        logic [1:0] strap_wait;
        logic [5:0] node;
        logic [3:0] unit;
        logic addr_err;
        logic lamp;
        logic param_err;
        logic run;
        logic [6:0] net_addr;
        logic [6:0] dest_net;
        logic [31:0] remote_par;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [16:0] ms_cnt;
        logic [7:0] cyc_ms;
        logic cyc_stb;
        logic [7:0] ev_cnt;
        logic ev_grant;
        logic ev_deny;
        logic [5:0] tok_next;
        logic [5:0] poll_ptr;
        logic [5:0] poll_left;
        logic [5:0] poll_addr;
        logic poll_stb;
        logic route_local;
        logic [15:0] ref_cnt;
        logic ref_busy;
        logic [4:0] hw_idx;
        logic host_wr;
        logic host_area;
        logic [15:0] host_addr;
        logic [15:0] host_data;
    } tbn_state_t;

    tbn_state_t r;
    tbn_state_t r_nxt;

    logic mem_we;
    logic [1:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [3:0][7:0] par;

    tbn_param_mem #(
        .W(8),
        .N(4)
    ) u_par (
        .clk(pclk),
        .rst_n(presetn),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .cells(par)
    );

    // ==========================================================
    // helpers
    function automatic logic [5:0] lowest(input logic [61:0] v);
        logic [5:0] res;
        res = '0;
        for (int i = tbn_pkg::NODES; i >= 1; i--)
        begin
            if (v[i-1])
            begin
                res = 6'(i);
            end
        end
        return res;
    endfunction

    function automatic logic in_range(input logic [7:0] v,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    // ==========================================================
    // effective parameters and ring view
    logic [61:0] own_vec;
    logic [61:0] ring_vec;
    logic [61:0] above_vec;
    logic [5:0] poll_node;
    logic is_poll;
    logic [7:0] eff_cyc;
    logic [7:0] eff_max;
    logic [7:0] eff_poll;
    logic [7:0] eff_frm;
    logic [8:0] ev_allow;
    logic fixed_mode;

    assign own_vec = (r.strap_done && !r.addr_err) ?
                     (62'h1 << (r.node - 6'h01)) : '0;
    // nodes above the max address never join the ring
    always_comb
    begin
        ring_vec = '0;
        above_vec = '0;
        for (int i = 1; i <= tbn_pkg::NODES; i++)
        begin
            ring_vec[i-1] = (r.part_s2[i-1] | own_vec[i-1]) &&
                            (8'(i) <= eff_max);
            above_vec[i-1] = ring_vec[i-1] && (6'(i) > r.node);
        end
    end

    assign poll_node = lowest(r.part_s2 | own_vec);
    assign is_poll = (own_vec != '0) && (poll_node == r.node);
    // a non-polling node ignores its own stored copy
    assign eff_cyc = is_poll ? par[tbn_pkg::SLOT_CYC] :
                     r.remote_par[7:0];
    assign eff_max = is_poll ? par[tbn_pkg::SLOT_MAX] :
                     r.remote_par[15:8];
    assign eff_poll = is_poll ? par[tbn_pkg::SLOT_POLL] :
                      r.remote_par[23:16];
    assign eff_frm = is_poll ? par[tbn_pkg::SLOT_FRM] :
                     r.remote_par[31:24];
    // 10 frames give 4 events, each further 3 frames one more
    assign ev_allow = ({1'b0, eff_frm} + tbn_pkg::FRM_ROUND) /
                      tbn_pkg::FRM_PER_EVENT;
    assign fixed_mode = r.run && (eff_cyc != tbn_pkg::CYC_AUTO);

    // ==========================================================
    // status word image for the core I/O window
    function automatic logic [15:0] cio_word(input logic [4:0] idx,
                                             input tbn_state_t s,
                                             input logic [5:0] pn);
        logic [15:0] w;
        w = '0;
        unique case (idx)
            5'h01:
            begin
                w[tbn_pkg::ST_ERR_PARAM] = s.param_err;
                w[tbn_pkg::ST_ERR_ADDR] = s.addr_err;
            end
            5'h02: w = s.part_s2[15:0];
            5'h03: w = s.part_s2[31:16];
            5'h04: w = s.part_s2[47:32];
            5'h05: w = {2'b00, s.part_s2[61:48]};
            5'h06: w = {1'b0, s.net_addr, 2'b00, s.node};
            5'h07: w = {4'h0, s.unit, 2'b00, pn};
            5'h17: w[tbn_pkg::ST_LINK_ACTIVE] = s.run;
            default: w = '0;
        endcase
        return w;
    endfunction

    // ==========================================================
    // next state
    always_comb
    begin
        logic [7:0] tens;
        logic [7:0] node_sum;
        logic wr_ok;
        logic [7:0] wv;
        logic [4:0] dm_idx;
        tens = '0;
        node_sum = '0;
        wr_ok = 1'b0;
        wv = pwdata[7:0];
        dm_idx = '0;
        r_nxt = r;
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_wdata = pwdata[7:0];
        r_nxt.cyc_stb = 1'b0;
        r_nxt.poll_stb = 1'b0;
        r_nxt.ev_grant = 1'b0;
        r_nxt.ev_deny = 1'b0;
        r_nxt.host_wr = 1'b0;

        // pins cross in through two flops
        r_nxt.sw_s1 = {unit_sw, addr_tens_sw, addr_ones_sw};
        r_nxt.sw_s2 = r.sw_s1;
        r_nxt.part_s1 = node_part;
        r_nxt.part_s2 = r.part_s1;
        r_nxt.tok_s1 = token_return;
        r_nxt.tok_s2 = r.tok_s1;
        r_nxt.tok_s3 = r.tok_s2;
        r_nxt.strap_wait = {r.strap_wait[0], 1'b1};

        // switches caught once the sync stages hold pin values, then frozen
        if (!r.strap_done && r.strap_wait[1])
        begin
            tens = {4'h0, r.sw_s2[7:4]};
            node_sum = 8'((tens << 3) + (tens << 1)) +
                       {4'h0, r.sw_s2[3:0]};
            r_nxt.strap_done = 1'b1;
            r_nxt.unit = r.sw_s2[11:8];
            r_nxt.node = node_sum[5:0];
            r_nxt.addr_err = (r.sw_s2[7:4] > tbn_pkg::DIGIT_MAX) ||
                (r.sw_s2[3:0] > tbn_pkg::DIGIT_MAX) ||
                !in_range(node_sum, 8'(tbn_pkg::NODE_MIN),
                          8'(tbn_pkg::NODE_MAX));
            r_nxt.lamp = r_nxt.addr_err;
        end

        // apb: setup cycle loads the answer, access cycle completes
        r_nxt.pready = 1'b0;
        if (psel && !penable)
        begin
            r_nxt.pready = 1'b1;
            r_nxt.pslverr = 1'b0;
            r_nxt.prdata = '0;
            unique case (paddr)
                tbn_pkg::OFS_CTRL: r_nxt.prdata[0] = r.run;
                tbn_pkg::OFS_CYC_TIME:
                    r_nxt.prdata[7:0] = par[tbn_pkg::SLOT_CYC];
                tbn_pkg::OFS_MAX_NODE:
                    r_nxt.prdata[7:0] = par[tbn_pkg::SLOT_MAX];
                tbn_pkg::OFS_POLL_CNT:
                    r_nxt.prdata[7:0] = par[tbn_pkg::SLOT_POLL];
                tbn_pkg::OFS_MAX_FRM:
                    r_nxt.prdata[7:0] = par[tbn_pkg::SLOT_FRM];
                tbn_pkg::OFS_NET_ADDR: r_nxt.prdata[6:0] = r.net_addr;
                tbn_pkg::OFS_REMOTE_PAR: r_nxt.prdata = r.remote_par;
                tbn_pkg::OFS_STATUS:
                    r_nxt.prdata = {11'h000, r.tok_next, poll_node,
                                    is_poll, r.param_err, r.addr_err,
                                    r.node};
                tbn_pkg::OFS_PART_LO: r_nxt.prdata = r.part_s2[31:0];
                tbn_pkg::OFS_PART_HI:
                    r_nxt.prdata = {2'b00, r.part_s2[61:32]};
                tbn_pkg::OFS_DEST_NET: r_nxt.prdata[6:0] = r.dest_net;
                default: r_nxt.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && r.pready && pwrite && !r.pslverr)
        begin
            // out-of-range values for the four parameter slots are refused and flagged
            unique case (paddr)
                tbn_pkg::OFS_CTRL: r_nxt.run = pwdata[0];
                tbn_pkg::OFS_CYC_TIME:
                begin
                    mem_waddr = tbn_pkg::SLOT_CYC;
                    wr_ok = (wv == tbn_pkg::CYC_AUTO) ||
                        in_range(wv, tbn_pkg::CYC_MIN,
                                 tbn_pkg::CYC_MAX);
                end
                tbn_pkg::OFS_MAX_NODE:
                begin
                    mem_waddr = tbn_pkg::SLOT_MAX;
                    wr_ok = in_range(wv, tbn_pkg::MAXN_MIN,
                                     tbn_pkg::MAXN_MAX);
                end
                tbn_pkg::OFS_POLL_CNT:
                begin
                    mem_waddr = tbn_pkg::SLOT_POLL;
                    wr_ok = in_range(wv, tbn_pkg::POLL_MIN,
                                     tbn_pkg::POLL_MAX);
                end
                tbn_pkg::OFS_MAX_FRM:
                begin
                    mem_waddr = tbn_pkg::SLOT_FRM;
                    wr_ok = in_range(wv, tbn_pkg::FRM_MIN,
                                     tbn_pkg::FRM_MAX);
                end
                tbn_pkg::OFS_NET_ADDR: r_nxt.net_addr = pwdata[6:0];
                tbn_pkg::OFS_REMOTE_PAR: r_nxt.remote_par = pwdata;
                tbn_pkg::OFS_DEST_NET: r_nxt.dest_net = pwdata[6:0];
                default: wr_ok = 1'b0;
            endcase
            if (paddr inside {tbn_pkg::OFS_CYC_TIME,
                tbn_pkg::OFS_MAX_NODE, tbn_pkg::OFS_POLL_CNT,
                tbn_pkg::OFS_MAX_FRM})
            begin
                mem_we = wr_ok && (pwdata[31:8] == '0);
                r_nxt.param_err = !mem_we;
            end
        end

        // network 0 or our own network stays local
        r_nxt.route_local = (r.dest_net == tbn_pkg::NET_LOCAL) ||
                            (r.dest_net == r.net_addr);

        // cycle end: fixed timer while linked with a non-auto cycle time, else token return
        if (fixed_mode)
        begin
            r_nxt.ms_cnt = r.ms_cnt + 17'h00001;
            if (r.ms_cnt == 17'(MS_CYCLES - 1))
            begin
                r_nxt.ms_cnt = '0;
                r_nxt.cyc_ms = r.cyc_ms + 8'h01;
                if (r.cyc_ms + 8'h01 >= eff_cyc)
                begin
                    r_nxt.cyc_ms = '0;
                    r_nxt.cyc_stb = 1'b1;
                end
            end
        end
        else
        begin
            r_nxt.ms_cnt = '0;
            r_nxt.cyc_ms = '0;
            r_nxt.cyc_stb = r.tok_s2 && !r.tok_s3;
        end

        // token successor; wrap to lowest node closes the ring
        r_nxt.tok_next = (above_vec != '0) ? lowest(above_vec) :
                         lowest(ring_vec);

        // event budget per token cycle while links run
        if (r.cyc_stb)
        begin
            r_nxt.ev_cnt = '0;
        end
        if (ev_req)
        begin
            if (!r.run || ({1'b0, r_nxt.ev_cnt} < ev_allow))
            begin
                r_nxt.ev_grant = 1'b1;
                r_nxt.ev_cnt = r_nxt.ev_cnt + (r.run ? 8'h01 : 8'h00);
            end
            else
            begin
                r_nxt.ev_deny = 1'b1;
            end
        end

        // polling node walks a window of nodes each cycle
        if (r.cyc_stb && is_poll)
        begin
            r_nxt.poll_left = eff_poll[5:0];
        end
        else if (r.poll_left != '0)
        begin
            r_nxt.poll_left = r.poll_left - 6'h01;
            r_nxt.poll_stb = 1'b1;
            r_nxt.poll_addr = r.poll_ptr;
            r_nxt.poll_ptr = ({2'b00, r.poll_ptr} >= eff_max) ?
                             tbn_pkg::NODE_MIN :
                             r.poll_ptr + 6'h01;
        end
        if ({2'b00, r.poll_ptr} > eff_max)
        begin
            r_nxt.poll_ptr = tbn_pkg::NODE_MIN;
        end

        // periodic refresh of the host windows
        r_nxt.ref_cnt = r.ref_cnt + 16'h0001;
        if (r.ref_cnt == 16'(REFRESH_CYCLES - 1))
        begin
            r_nxt.ref_cnt = '0;
            r_nxt.ref_busy = r.strap_done;
        end
        if (r.ref_busy)
        begin
            r_nxt.host_wr = 1'b1;
            r_nxt.hw_idx = r.hw_idx + 5'h01;
            if (r.hw_idx < tbn_pkg::CIO_WORDS)
            begin
                r_nxt.host_area = 1'b0;
                r_nxt.host_addr = tbn_pkg::CIO_BASE +
                    16'(r.unit) * tbn_pkg::CIO_STEP +
                    16'(r.hw_idx);
                r_nxt.host_data = cio_word(r.hw_idx, r, poll_node);
            end
            else
            begin
                dm_idx = r.hw_idx - tbn_pkg::CIO_WORDS;
                r_nxt.host_area = 1'b1;
                r_nxt.host_addr = tbn_pkg::DM_BASE +
                    16'(r.unit) * tbn_pkg::DM_STEP +
                    16'(dm_idx);
                unique case (dm_idx[1:0])
                    2'h0: r_nxt.host_data = {8'h00, eff_cyc};
                    2'h1: r_nxt.host_data = {8'h00, eff_max};
                    2'h2: r_nxt.host_data = {8'h00, eff_poll};
                    2'h3: r_nxt.host_data = {8'h00, eff_frm};
                endcase
                if (dm_idx == tbn_pkg::DM_WORDS - 5'h01)
                begin
                    r_nxt.hw_idx = '0;
                    r_nxt.ref_busy = 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.poll_ptr <= tbn_pkg::NODE_MIN;
            r.route_local <= 1'b1;
        end
        else
        begin
            r <= r_nxt;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign comm_error_lamp = r.lamp;
    assign token_next = r.tok_next;
    assign cycle_strobe = r.cyc_stb;
    assign poll_strobe = r.poll_stb;
    assign poll_addr = r.poll_addr;
    assign ev_grant = r.ev_grant;
    assign ev_deny = r.ev_deny;
    assign route_local = r.route_local;
    assign host_wr = r.host_wr;
    assign host_area = r.host_area;
    assign host_addr = r.host_addr;
    assign host_data = r.host_data;

endmodule

// ===== core/tbn_param_mem.sv
module tbn_param_mem #(
    parameter int W = 8,
    parameter int N = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // write port
    input wire logic we,
    input wire logic [$clog2(N)-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // every cell, straight from its flip-flops
    output logic [N-1:0][W-1:0] cells
);

    typedef struct packed {
        logic [N-1:0][W-1:0] mem;
    } tbn_mem_st_t;

    tbn_mem_st_t r;
    tbn_mem_st_t r_nxt;

    // ==========================================================
    // storage
    always_comb
    begin
        r_nxt = r;
        if (we)
        begin
            r_nxt.mem[waddr] = wdata;
        end
    end

    // every reset reloads the defaults; writes persist only until the next reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r.mem <= '0;
            r.mem[tbn_pkg::SLOT_CYC] <= W'(tbn_pkg::CYC_AUTO);
            r.mem[tbn_pkg::SLOT_MAX] <= W'(tbn_pkg::MAXN_DEF);
            r.mem[tbn_pkg::SLOT_POLL] <= W'(tbn_pkg::POLL_DEF);
            r.mem[tbn_pkg::SLOT_FRM] <= W'(tbn_pkg::FRM_DEF);
        end
        else
        begin
            r <= r_nxt;
        end
    end

    assign cells = r.mem;

endmodule

// ===== include/tbn_pkg.sv
package tbn_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_HZ = 100_000_000;
    localparam int CYC_UNIT_MS = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * CYC_UNIT_MS;
    localparam int REFRESH_US = 10;
    localparam int REFRESH_CYCLES = CLK_HZ / 1_000_000 * REFRESH_US;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CYC_TIME = 8'h04;
    localparam logic [7:0] OFS_MAX_NODE = 8'h08;
    localparam logic [7:0] OFS_POLL_CNT = 8'h0C;
    localparam logic [7:0] OFS_MAX_FRM = 8'h10;
    localparam logic [7:0] OFS_NET_ADDR = 8'h14;
    localparam logic [7:0] OFS_REMOTE_PAR = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_PART_LO = 8'h20;
    localparam logic [7:0] OFS_PART_HI = 8'h24;
    localparam logic [7:0] OFS_DEST_NET = 8'h28;

    // ==========================================================
    // parameter store slots, defaults and ranges
    localparam logic [1:0] SLOT_CYC = 2'h0;
    localparam logic [1:0] SLOT_MAX = 2'h1;
    localparam logic [1:0] SLOT_POLL = 2'h2;
    localparam logic [1:0] SLOT_FRM = 2'h3;
    localparam logic [7:0] CYC_AUTO = 8'h00;
    localparam logic [7:0] CYC_MIN = 8'h05;
    localparam logic [7:0] CYC_MAX = 8'hFF;
    localparam logic [7:0] MAXN_DEF = 8'h3E;
    localparam logic [7:0] MAXN_MIN = 8'h02;
    localparam logic [7:0] MAXN_MAX = 8'h3E;
    localparam logic [7:0] POLL_DEF = 8'h04;
    localparam logic [7:0] POLL_MIN = 8'h01;
    localparam logic [7:0] POLL_MAX = 8'h3E;
    localparam logic [7:0] FRM_DEF = 8'h0A;
    localparam logic [7:0] FRM_MIN = 8'h05;
    localparam logic [7:0] FRM_MAX = 8'hFF;
    localparam logic [8:0] FRM_ROUND = 9'h002;
    localparam logic [8:0] FRM_PER_EVENT = 9'h003;

    // ==========================================================
    // node and network addressing
    localparam int NODES = 62;
    localparam logic [5:0] NODE_MIN = 6'h01;
    localparam logic [5:0] NODE_MAX = 6'h3E;
    localparam logic [6:0] NET_LOCAL = 7'h00;
    localparam logic [3:0] DIGIT_MAX = 4'h9;

    // ==========================================================
    // host status windows
    localparam logic [15:0] CIO_BASE = 16'h05DC;
    localparam logic [15:0] CIO_STEP = 16'h0019;
    localparam logic [15:0] DM_BASE = 16'h7530;
    localparam logic [15:0] DM_STEP = 16'h0064;
    localparam logic [4:0] CIO_WORDS = 5'h19;
    localparam logic [4:0] DM_WORDS = 5'h04;
    localparam int ST_ERR_PARAM = 0;
    localparam int ST_ERR_ADDR = 8;
    localparam int ST_LINK_ACTIVE = 15;

endpackage

// ===== sim/tbn_far_nodes.sv
module tbn_far_nodes #(
    parameter logic [61:0] PART = 62'h0
) (
    // clock and bench request to close a token round
    input wire logic pclk,
    input wire logic kick,
    // network pins
    output logic [61:0] node_part,
    output logic token_return
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] hold_r = 3'h0;
    assign node_part = PART;
    // held four clocks so the two-stage sync cannot miss it
    always_ff @(posedge pclk)
        if (kick)
            hold_r <= 3'h4;
        else if (hold_r != 3'h0)
            hold_r <= hold_r - 3'h1;
    assign token_return = hold_r != 3'h0;
endmodule

// ===== sim/tbn_node_cfg_properties.sv
module tbn_node_cfg_properties (
    // clock, reset and apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // network and host side
    input wire logic ev_req,
    input wire logic ev_grant,
    input wire logic ev_deny,
    input wire logic comm_error_lamp,
    input wire logic poll_strobe,
    input wire logic [5:0] poll_addr,
    input wire logic host_wr,
    input wire logic host_area,
    input wire logic [15:0] host_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========================================================
    // apb answer: one cycle after setup, high for one cycle only
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    property p_rdy; s_setup |=> s_answer; endproperty
    a_rdy: assert property (p_rdy) else $error("pready timing wrong");
    // ==========================================================
    // network side
    property p_ev; ev_req |=> ev_grant != ev_deny; endproperty
    a_ev: assert property (p_ev) else $error("event not answered");
    property p_evq; !ev_req |=> !ev_grant && !ev_deny; endproperty
    a_evq: assert property (p_evq) else $error("answer unasked");
    property p_lamp; comm_error_lamp |=> comm_error_lamp; endproperty
    a_lamp: assert property (p_lamp) else $error("lamp dropped");
    property p_poll; poll_strobe |-> poll_addr inside {[1:62]}; endproperty
    a_poll: assert property (p_poll) else $error("poll address bad");
    // ==========================================================
    // host windows
    property p_cio;
        host_wr && !host_area |-> host_addr inside {[16'h05DC:16'h076B]};
    endproperty
    a_cio: assert property (p_cio) else $error("core io address");
    property p_dm;
        host_wr && host_area |-> host_addr inside {[16'h7530:16'h7B6F]};
    endproperty
    a_dm: assert property (p_dm) else $error("data mem address");
    property p_burst; $rose(host_wr) |-> host_wr [*8]; endproperty
    a_burst: assert property (p_burst) else $error("burst broken");
endmodule

bind tbn_node_cfg tbn_node_cfg_properties u_props (.pclk, .presetn, .psel,
    .penable, .pready, .ev_req, .ev_grant, .ev_deny, .comm_error_lamp,
    .poll_strobe, .poll_addr, .host_wr, .host_area, .host_addr);

// ===== sim/tbn_node_cfg_tb.sv
module tbn_node_cfg_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, ev_req = 1'b0, kick = 1'b0, e, token_return;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, r = 32'h680FBA44;
    logic [3:0] addr_tens_sw = 4'h3, addr_ones_sw = 4'h7, unit_sw = 4'h0;
    logic pready, pslverr, comm_error_lamp, cycle_strobe, poll_strobe;
    logic ev_grant, ev_deny, route_local, host_wr, host_area;
    logic [5:0] token_next, poll_addr;
    logic [15:0] host_addr, host_data;
    logic [61:0] node_part;
    int bad_count = 0, num_checks = 0, i, k, g, v;
    int LO [4] = '{5, 2, 1, 5}, HI [4] = '{255, 62, 62, 255};
    logic [7:0] PA [4] = '{8'h04, 8'h08, 8'h0C, 8'h10};
    tbn_far_nodes #(.PART(62'h0002008000000000)) u_tbn_far_nodes (.pclk,
        .kick, .node_part, .token_return);
    tbn_node_cfg #(.MS_CYCLES(10), .REFRESH_CYCLES(100)) u_tbn_node_cfg (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .addr_tens_sw, .addr_ones_sw, .unit_sw,
        .comm_error_lamp, .node_part, .token_return, .ev_req, .token_next,
        .cycle_strobe, .poll_strobe, .poll_addr, .ev_grant, .ev_deny,
        .route_local, .host_wr, .host_area, .host_addr, .host_data);
    initial forever #5 pclk = ~pclk;
    function automatic logic [31:0] rnd();
        r = r ^ (r << 13);
        r = r ^ (r >> 17);
        r = r ^ (r << 5);
        return r;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (k >= n)
        begin
            bad_count++;
            $display("[FAIL] %0t wait ran out", $time);
            tally_and_finish();
        end
    endtask
    // ==========================================================
    // apb master: request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 20 && pready !== 1'b1; k++)
            @(posedge pclk);
        tmo(20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input int x);
        apb(1'b0, a, 0);
        chk(q, 32'(x));
    endtask
    task automatic strobe(input int n);
        for (k = 0; k < n && cycle_strobe !== 1'b1; k++)
            @(posedge pclk);
        tmo(n);
    endtask
    // events after a fresh cycle; three frames buy one more event
    task automatic evs(input int f);
        apb(1'b1, 8'h10, f);
        apb(1'b1, 8'h00, 1);
        kick <= 1'b1;
        @(posedge pclk);
        kick <= 1'b0;
        strobe(40);
        g = 0;
        repeat (8)
        begin
            @(posedge pclk);
            ev_req <= 1'b1;
            @(posedge pclk);
            ev_req <= 1'b0;
            @(posedge pclk);
            g += int'(ev_grant === 1'b1);
        end
        chk(32'(g), 32'(4 + (f - 10) / 3));
        apb(1'b1, 8'h00, 0);
    endtask
    initial
    begin
        unit_sw <= 4'(rnd());
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 4; i++)
            rdc(PA[i], i == 0 ? 0 : i == 1 ? 62 : i == 2 ? 4 : 10);
        addr_tens_sw <= 4'h9;
        rdc(8'h1C, {11'h000, 6'h28, 6'h25, 3'h4, 6'h25});
        chk(comm_error_lamp, 0);
        rdc(8'h20, 0);
        rdc(8'h24, 32'h00020080);
        apb(1'b0, 8'h40, 0);
        chk({e, q[30:0]}, 32'h80000000);
        $display("test address and defaults done");
        for (k = 0; k < 400 && !(host_wr === 1'b1 && host_addr ===
                16'h05DC + 16'h0019 * unit_sw + 16'h0006); k++)
            @(posedge pclk);
        tmo(400);
        chk(host_data, 16'h0025);
        for (k = 0; k < 400 && !(host_wr === 1'b1 && host_addr ===
                16'h7530 + 16'h0064 * unit_sw + 16'h0001); k++)
            @(posedge pclk);
        tmo(400);
        chk(host_data, 16'h003E);
        $display("test host windows done");
        for (i = 0; i < 4; i++)
        begin
            v = LO[i] + int'(rnd() % (HI[i] - LO[i] + 1));
            apb(1'b1, PA[i], v);
            rdc(PA[i], v);
            apb(1'b1, PA[i], HI[i] + 1);
            apb(1'b1, PA[i], LO[i] - 1);
            rdc(PA[i], v);
        end
        apb(1'b0, 8'h1C, 0);
        chk(q[7], 1);
        $display("test parameter ranges done");
        apb(1'b1, 8'h04, 5);
        apb(1'b1, 8'h00, 1);
        strobe(200);
        @(posedge pclk);
        strobe(200);
        chk(32'(k + 1), 32'(5 * 10));
        apb(1'b1, 8'h00, 0);
        @(posedge pclk);
        for (k = 0; k < 120 && cycle_strobe !== 1'b1; k++)
            @(posedge pclk);
        chk(32'(k), 32'(120));
        apb(1'b1, 8'h04, 0);
        evs(10);
        evs(10 + 3 * int'(rnd() % 3));
        $display("test cycle timer and events done");
        apb(1'b1, 8'h14, 9);
        for (i = 0; i < 4; i++)
        begin
            v = i == 0 ? 0 : i == 1 ? 9 : 1 + int'(rnd() % 127);
            apb(1'b1, 8'h28, v);
            repeat (2) @(posedge pclk);
            chk(route_local, v == 0 || v == 9);
        end
        $display("test routing done");
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(comm_error_lamp, 1);
        apb(1'b0, 8'h1C, 0);
        chk(q[6], 1);
        $display("test invalid address done");
        tally_and_finish();
    end
endmodule
